// File: src/cbt_pkg.sv
// Package: register map, field layout, types and constants for bit timing and receiver flags
package cbt_pkg;
    // Byte addresses of the word registers
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_BTR0   = 8'h04;
    localparam logic [7:0] ADDR_BTR1   = 8'h0c;
    localparam logic [7:0] ADDR_RFLG   = 8'h10;
    localparam logic [7:0] ADDR_RIER   = 8'h14;
    localparam logic [7:0] ADDR_ERRCNT = 8'h18;
    // Timing register 1 fields
    localparam int BTR1_TRIPLE_SAMPLE_SELECT_BIT = 7;
    localparam int BTR1_SEG2_LSB = 4;
    localparam int BTR1_SEG1_LSB = 0;
    // Receiver flag register bit positions
    localparam int RF_WAKE = 7;
    localparam int RF_CSC  = 6;
    localparam int RF_RS1  = 5;
    localparam int RF_RS0  = 4;
    localparam int RF_TS1  = 3;
    localparam int RF_TS0  = 2;
    localparam int RF_OVR  = 1;
    localparam int RF_RXF  = 0;
    // Control register bit positions
    localparam int CTRL_INIT_RQ = 0;
    localparam int CTRL_INIT_AK = 1;
    localparam int CTRL_WAKE_EN = 2;
    localparam int CTRL_SLEEP   = 3;
    // Reset values
    localparam logic [7:0] BTR0_RESET = 8'h00;
    localparam logic [7:0] BTR1_RESET = 8'h00;
    localparam logic [7:0] RFLG_RESET = 8'h00;
    localparam logic [7:0] RIER_RESET = 8'h00;
    // Error state thresholds
    localparam logic [8:0] LIM_WARN = 9'h060;
    localparam logic [8:0] LIM_PASS = 9'h07f;
    localparam logic [8:0] LIM_BOFF = 9'h0ff;
    // Counter steps
    localparam logic [8:0] ERR_STEP_BIG = 9'h008;
    localparam logic [8:0] ERR_STEP_ONE = 9'h001;

    typedef enum logic [1:0] {
        ST_OK   = 2'h0,
        ST_WARN = 2'h1,
        ST_ERR  = 2'h2,
        ST_BOFF = 2'h3
    } bus_state_t;

    typedef struct packed {
        logic       triple;
        logic [2:0] seg2;
        logic [3:0] seg1;
    } timing_t;

    typedef struct packed {
        logic rx_error;
        logic rx_ok;
        logic tx_error;
        logic tx_ok;
        logic bus_recover;
    } err_event_t;
endpackage : cbt_pkg

// File: src/cbt_bit_timer.sv
// Bit timer: quantum prescaler, segment sequencing and bus sampling
`timescale 1ns/100ps
`default_nettype none
module cbt_bit_timer #(
    parameter int PRESC_W = 6
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               ce,
    input  wire logic               run,
    input  wire logic [PRESC_W-1:0] prescale,
    input  wire cbt_pkg::timing_t   timing,
    input  wire logic               rx_in,
    output logic                    bit_strobe,
    output logic                    bit_value
);
    initial begin
        if (PRESC_W < 1 || PRESC_W > 8) $error("PRESC_W out of range");
    end

    logic [PRESC_W-1:0] presc_reg;
    logic [4:0]         quantum_reg;
    logic [2:0]         hist_reg;
    logic               bit_strobe_reg;
    logic               bit_value_reg;

    wire        tq_tick    = (presc_reg == prescale);
    // Bit spans 1 + (seg1+1) + (seg2+1) quanta
    wire [4:0]  last_q     = 5'(timing.seg1) + 5'(timing.seg2) + 5'h02;
    wire [4:0]  sample_q   = 5'(timing.seg1) + 5'h01;
    wire        at_sample  = tq_tick && (quantum_reg == sample_q);
    wire [2:0]  hist_next  = {hist_reg[1:0], rx_in};
    wire        majority   = (hist_next[0] & hist_next[1]) | (hist_next[0] & hist_next[2])
                             | (hist_next[1] & hist_next[2]);
    wire        sampled    = timing.triple ? majority : rx_in;

    always_ff @(posedge clk) begin
        if (!rst_n || !run) begin
            presc_reg      <= '0;
            quantum_reg    <= 5'h00;
            hist_reg       <= 3'h7;
            bit_strobe_reg <= 1'b0;
            bit_value_reg  <= 1'b1;
        end else if (ce) begin
            presc_reg      <= tq_tick ? '0 : presc_reg + 1'b1;
            bit_strobe_reg <= at_sample;
            if (tq_tick) begin
                quantum_reg <= (quantum_reg == last_q) ? 5'h00 : quantum_reg + 5'h01;
                hist_reg    <= hist_next;
            end
            if (at_sample) begin
                bit_value_reg <= sampled;
            end
        end
    end

    assign bit_strobe = bit_strobe_reg;
    assign bit_value  = bit_value_reg;
endmodule : cbt_bit_timer
`default_nettype wire

// File: src/cbt_top.sv
// Top: APB registers, receiver flags, error state tracking and bit timer
`timescale 1ns/100ps
`default_nettype none
module cbt_top #(
    parameter int PRESC_W = 6
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RESET_N,
    input  wire logic        CLK_EN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        RX_IN,
    input  wire logic        RX_MSG_OK,
    input  wire logic        RX_OVERRUN,
    input  wire cbt_pkg::err_event_t ERR_EVENT,
    output logic             RX_SHIFT,
    output logic             BIT_STROBE,
    output logic             BIT_VALUE,
    output logic             WAKE_IRQ,
    output logic             ERROR_IRQ,
    output logic             RX_IRQ
);
    initial begin
        if (PRESC_W != 6) $error("PRESC_W must match the prescaler field");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode
    wire       setup_ph  = PSEL && !PENABLE;
    wire       access_ph = PSEL && PENABLE;
    wire       wr_en     = access_ph && PWRITE && CLK_EN;
    wire       hit_ctrl  = (PADDR == cbt_pkg::ADDR_CTRL);
    wire       hit_btr0  = (PADDR == cbt_pkg::ADDR_BTR0);
    wire       hit_btr1  = (PADDR == cbt_pkg::ADDR_BTR1);
    wire       hit_rflg  = (PADDR == cbt_pkg::ADDR_RFLG);
    wire       hit_rier  = (PADDR == cbt_pkg::ADDR_RIER);
    wire       hit_cnt   = (PADDR == cbt_pkg::ADDR_ERRCNT);
    wire       mapped    = hit_ctrl | hit_btr0 | hit_btr1 | hit_rflg | hit_rier | hit_cnt;

    logic [3:0]  ctrl_reg;
    logic [7:0]  btr0_reg;
    logic [7:0]  btr1_reg;
    logic [7:0]  rflg_reg;
    logic [7:0]  rier_reg;
    logic [8:0]  tec_reg;
    logic [7:0]  rec_reg;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic        rx_prev_reg;
    logic        shift_reg;
    logic        wake_irq_reg;
    logic        err_irq_reg;
    logic        rx_irq_reg;

    wire in_init  = ctrl_reg[cbt_pkg::CTRL_INIT_RQ] && ctrl_reg[cbt_pkg::CTRL_INIT_AK];
    wire out_init = !ctrl_reg[cbt_pkg::CTRL_INIT_RQ] && !ctrl_reg[cbt_pkg::CTRL_INIT_AK];

    ////////////////////////////////////////////////////////////////////////////////
    // Error state decode
    function automatic cbt_pkg::bus_state_t tx_state(input logic [8:0] tx_error_count);
        if (tx_error_count > cbt_pkg::LIM_BOFF)      tx_state = cbt_pkg::ST_BOFF;
        else if (tx_error_count > cbt_pkg::LIM_PASS) tx_state = cbt_pkg::ST_ERR;
        else if (tx_error_count > cbt_pkg::LIM_WARN) tx_state = cbt_pkg::ST_WARN;
        else                              tx_state = cbt_pkg::ST_OK;
    endfunction : tx_state

    function automatic cbt_pkg::bus_state_t rx_state(input logic [7:0] rx_error_count, input logic [8:0] tx_error_count);
        if (tx_error_count > cbt_pkg::LIM_BOFF)             rx_state = cbt_pkg::ST_BOFF;
        else if ({1'b0, rx_error_count} > cbt_pkg::LIM_PASS) rx_state = cbt_pkg::ST_ERR;
        else if ({1'b0, rx_error_count} > cbt_pkg::LIM_WARN) rx_state = cbt_pkg::ST_WARN;
        else                                      rx_state = cbt_pkg::ST_OK;
    endfunction : rx_state

    // Bus-off exit clears both counts, so the receiver also decodes OK
    wire [1:0] live_rs   = rx_state(rec_reg, tec_reg);
    wire [1:0] live_ts   = tx_state(tec_reg);
    wire [1:0] shown_rs  = {rflg_reg[cbt_pkg::RF_RS1], rflg_reg[cbt_pkg::RF_RS0]};
    wire [1:0] shown_ts  = {rflg_reg[cbt_pkg::RF_TS1], rflg_reg[cbt_pkg::RF_TS0]};
    wire       csc_busy  = rflg_reg[cbt_pkg::RF_CSC];
    wire       st_change = (live_rs != shown_rs) || (live_ts != shown_ts);
    wire       st_load   = st_change && !csc_busy;

    ////////////////////////////////////////////////////////////////////////////////
    // Fault confinement counters
    wire [8:0] tec_up  = (tec_reg > 9'h1f7) ? 9'h100 : tec_reg + cbt_pkg::ERR_STEP_BIG;
    wire [8:0] tec_dn  = (tec_reg == 9'h000) ? 9'h000 : tec_reg - cbt_pkg::ERR_STEP_ONE;
    wire [7:0] rec_up  = (rec_reg > 8'hf7) ? 8'hff : rec_reg + 8'h08;
    wire [7:0] rec_dn  = (rec_reg > 8'h7f) ? 8'h77 : ((rec_reg == 8'h00) ? 8'h00 : rec_reg - 8'h01);
    wire       boff    = (tec_reg > cbt_pkg::LIM_BOFF);
    wire [8:0] tec_next = boff ? (ERR_EVENT.bus_recover ? 9'h000 : tec_reg)
                         : ERR_EVENT.tx_error ? tec_up
                         : ERR_EVENT.tx_ok ? tec_dn : tec_reg;
    wire [7:0] rec_next = (boff && ERR_EVENT.bus_recover) ? 8'h00
                         : ERR_EVENT.rx_error ? rec_up
                         : ERR_EVENT.rx_ok ? rec_dn : rec_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Flag events; set wins over a simultaneous clear
    wire       sleeping  = ctrl_reg[cbt_pkg::CTRL_SLEEP];
    wire       wake_ev   = sleeping && ctrl_reg[cbt_pkg::CTRL_WAKE_EN] && rx_prev_reg && !RX_IN;
    // No shift in init: the flag would be dropped and the message lost
    wire       rxf_set   = RX_MSG_OK && !rflg_reg[cbt_pkg::RF_RXF] && !in_init;
    wire [7:0] set_mask  = {wake_ev, st_load, 4'h0, RX_OVERRUN, rxf_set};
    wire [7:0] held      = {1'b0, 1'b0, 4'hf, 1'b0, 1'b0};
    // Clearable only once its cause has gone
    // Change flag has no lasting cause: a pending change must stay clearable
    wire [7:0] cause     = {wake_ev, 1'b0, 4'h0, RX_OVERRUN, RX_MSG_OK};
    wire       rflg_wr   = wr_en && hit_rflg && out_init;
    wire [7:0] clr_mask  = rflg_wr ? (PWDATA[7:0] & ~held & ~cause) : 8'h00;
    wire [7:0] flags_kept = (rflg_reg & ~clr_mask) | set_mask;
    wire [3:0] state_bits = st_load ? {live_rs, live_ts} : {shown_rs, shown_ts};
    wire [7:0] rflg_next = in_init ? ((cbt_pkg::RFLG_RESET & ~held) | (rflg_reg & held))
                         : {flags_kept[7:6], state_bits, flags_kept[1:0]};

    wire [3:0] ctrl_next = {PWDATA[3], PWDATA[2], ctrl_reg[cbt_pkg::CTRL_INIT_RQ], PWDATA[0]};
    wire [7:0] rier_next = in_init ? cbt_pkg::RIER_RESET
                         : (wr_en && hit_rier && out_init) ? PWDATA[7:0] : rier_reg;

    wire [31:0] rd_mux = hit_ctrl ? {28'h0, ctrl_reg}
                       : hit_btr0 ? {24'h0, btr0_reg}
                       : hit_btr1 ? {24'h0, btr1_reg}
                       : hit_rflg ? {24'h0, rflg_reg}
                       : hit_rier ? {24'h0, rier_reg}
                       : hit_cnt  ? {15'h0, tec_reg, rec_reg} : 32'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            ctrl_reg    <= 4'h0;
            btr0_reg    <= cbt_pkg::BTR0_RESET;
            btr1_reg    <= cbt_pkg::BTR1_RESET;
            rflg_reg    <= cbt_pkg::RFLG_RESET;
            rier_reg    <= cbt_pkg::RIER_RESET;
            tec_reg     <= 9'h000;
            rec_reg     <= 8'h00;
            rx_prev_reg <= 1'b1;
        end else if (CLK_EN) begin
            if (wr_en && hit_ctrl) begin
                ctrl_reg <= ctrl_next;
            end else begin
                // Acknowledge follows request one cycle later
                ctrl_reg[cbt_pkg::CTRL_INIT_AK] <= ctrl_reg[cbt_pkg::CTRL_INIT_RQ];
            end
            if (wr_en && hit_btr0 && in_init) begin
                btr0_reg <= PWDATA[7:0];
            end
            if (wr_en && hit_btr1 && in_init) begin
                btr1_reg <= PWDATA[7:0];
            end
            rflg_reg    <= rflg_next;
            rier_reg    <= rier_next;
            tec_reg     <= tec_next;
            rec_reg     <= rec_next;
            rx_prev_reg <= RX_IN;
        end
    end

    // Zero-wait APB: ready rises in the first access cycle
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            prdata_reg  <= 32'h0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (CLK_EN) begin
            pready_reg  <= setup_ph;
            pslverr_reg <= setup_ph && !mapped;
            prdata_reg  <= (setup_ph && !PWRITE) ? rd_mux : 32'h0;
        end
    end

    // Interrupt requests as registered flag-and-enable terms
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            wake_irq_reg <= 1'b0;
            err_irq_reg  <= 1'b0;
            rx_irq_reg   <= 1'b0;
            shift_reg    <= 1'b0;
        end else if (CLK_EN) begin
            wake_irq_reg <= rflg_next[cbt_pkg::RF_WAKE] && rier_next[cbt_pkg::RF_WAKE];
            err_irq_reg  <= (rflg_next[cbt_pkg::RF_CSC] && rier_next[cbt_pkg::RF_CSC])
                            || (rflg_next[cbt_pkg::RF_OVR] && rier_next[cbt_pkg::RF_OVR]);
            rx_irq_reg   <= rflg_next[cbt_pkg::RF_RXF] && rier_next[cbt_pkg::RF_RXF];
            shift_reg    <= rxf_set;
        end
    end

    assign PRDATA    = prdata_reg;
    assign PREADY    = pready_reg;
    assign PSLVERR   = pslverr_reg;
    assign RX_SHIFT  = shift_reg;
    assign WAKE_IRQ  = wake_irq_reg;
    assign ERROR_IRQ = err_irq_reg;
    assign RX_IRQ    = rx_irq_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Bit timer, stopped in init and sleep
    cbt_bit_timer #(
        .PRESC_W (PRESC_W)
    ) u_timer (
        .clk        (CORE_CLK),
        .rst_n      (RESET_N),
        .ce         (CLK_EN),
        .run        (out_init && !sleeping),
        .prescale   (btr0_reg[PRESC_W-1:0]),
        .timing     (cbt_pkg::timing_t'(btr1_reg)),
        .rx_in      (RX_IN),
        .bit_strobe (BIT_STROBE),
        .bit_value  (BIT_VALUE)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_init_hold;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (CLK_EN && in_init) |=> (rflg_reg[7:6] == 2'b00 && rflg_reg[1:0] == 2'b00);
    endproperty
    a_init_hold: assert property (p_init_hold) else $error("flags not held in init");

    property p_freeze;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (CLK_EN && csc_busy && !in_init) |=> $stable(rflg_reg[5:2]);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state code moved while pending");

    property p_csc_set;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (CLK_EN && !in_init && st_change && !csc_busy) |=> (csc_busy && shown_ts == $past(live_ts));
    endproperty
    a_csc_set: assert property (p_csc_set) else $error("state change not flagged");

    property p_rxf_block;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (CLK_EN && rflg_reg[cbt_pkg::RF_RXF]) |=> !RX_SHIFT;
    endproperty
    a_rxf_block: assert property (p_rxf_block) else $error("shift while full");

    property p_btr_lock;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (CLK_EN && !in_init) |=> $stable(btr1_reg);
    endproperty
    a_btr_lock: assert property (p_btr_lock) else $error("timing changed outside init");

    property p_rx_irq;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (CLK_EN && rflg_reg[cbt_pkg::RF_RXF] && rier_reg[cbt_pkg::RF_RXF] && !in_init) ##1 CLK_EN
        |-> ##1 RX_IRQ || !rflg_reg[cbt_pkg::RF_RXF];
    endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("receive irq missing");

    property p_tx_boff;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (CLK_EN && !csc_busy && !in_init && tec_reg > cbt_pkg::LIM_BOFF) |=> (shown_rs == 2'b11 && shown_ts == 2'b11);
    endproperty
    a_tx_boff: assert property (p_tx_boff) else $error("bus-off code wrong");

    property p_ovr_set;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (CLK_EN && RX_OVERRUN && !in_init) |=> rflg_reg[cbt_pkg::RF_OVR];
    endproperty
    a_ovr_set: assert property (p_ovr_set) else $error("overrun not flagged");
endmodule : cbt_top
`default_nettype wire

// File: tb/can_far_side.sv
// Far side model: bus level and receive and error event pulses
`timescale 1ns/100ps
`default_nettype none
module can_far_side (
    input  wire logic            clk,
    output logic                 rx_in,
    output logic                 msg_ok,
    output logic                 overrun,
    output cbt_pkg::err_event_t  err_ev
);
    // Recessive idle level, no events pending
    initial begin
        rx_in = 1'b1;
        {msg_ok, overrun, err_ev} = 7'h00;
    end
    ////////////////////////////////////////////////////////////////
    // One-cycle pulses with a quiet cycle between, as a real node gives
    task automatic ev(input logic [6:0] v, input int n);
        repeat (n) begin
            @(posedge clk);
            {msg_ok, overrun, err_ev} <= v;
            @(posedge clk);
            {msg_ok, overrun, err_ev} <= 7'h00;
        end
    endtask : ev
    task automatic bus(input logic v);
        @(posedge clk);
        rx_in <= v;
    endtask : bus
endmodule : can_far_side
`default_nettype wire

// File: tb/tb_cbt_top.sv
// Testbench: APB register tests against the bit timing and receiver flag block
`timescale 1ns/100ps
`default_nettype none
module tb_cbt_top;
    logic                clk, rst_n, psel, pen, pwr, err;
    logic [7:0]          paddr;
    logic [31:0]         pwdata, prdata, rd;
    logic                pready, pslverr, rx_in, msg_ok, ovr;
    cbt_pkg::err_event_t ev;
    logic                rx_shift, bstr, bval, wirq, eirq, rirq;
    logic                ce = 1'b1;
    int                  miscompares, cmp_count, shifts, per;
    logic [7:0]          pv [2] = '{8'h01, 8'h00};
    logic [7:0]          tv [2] = '{8'h23, 8'hff};
    int                  pexp [2] = '{16, 25};
    cbt_top u_dut (.CORE_CLK(clk), .RESET_N(rst_n), .CLK_EN(ce), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .RX_IN(rx_in), .RX_MSG_OK(msg_ok), .RX_OVERRUN(ovr), .ERR_EVENT(ev),
        .RX_SHIFT(rx_shift), .BIT_STROBE(bstr), .BIT_VALUE(bval), .WAKE_IRQ(wirq),
        .ERROR_IRQ(eirq), .RX_IRQ(rirq));
    can_far_side u_far (.clk(clk), .rx_in(rx_in), .msg_ok(msg_ok), .overrun(ovr), .err_ev(ev));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) if (rx_shift === 1'b1) shifts++;
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 40) begin
            n++;
            @(posedge clk);
        end
        if (n >= 40) miscompares++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; pen <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd & m, exp);
    endtask : rdc
    // Edges from one sample point strobe to the next, bounded
    task automatic measure(output int p);
        p = 0;
        do begin
            @(posedge clk);
            p++;
        end while (bstr !== 1'b1 && p < 400);
    endtask : measure
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        tally_and_finish;
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rdc(cbt_pkg::ADDR_BTR1, 32'hff, {24'h0, cbt_pkg::BTR1_RESET});
        rdc(cbt_pkg::ADDR_RFLG, 32'hff, {24'h0, cbt_pkg::RFLG_RESET});
        rdc(cbt_pkg::ADDR_RIER, 32'hff, {24'h0, cbt_pkg::RIER_RESET});
        apb(1'b0, 8'h08, 32'h0);
        check({31'h0, err}, 32'h1);
        wr(cbt_pkg::ADDR_BTR1, 32'h5a);
        rdc(cbt_pkg::ADDR_BTR1, 32'hff, 32'h0);
        wr(cbt_pkg::ADDR_RIER, 32'hc3);
        $display("test registers done");
        // Overrun flag, write one to clear
        u_far.ev(7'h20, 1);
        rdc(cbt_pkg::ADDR_RFLG, 32'h02, 32'h02);
        check({31'h0, eirq}, 32'h1);
        wr(cbt_pkg::ADDR_RFLG, 32'h00);
        rdc(cbt_pkg::ADDR_RFLG, 32'h02, 32'h02);
        wr(cbt_pkg::ADDR_RFLG, 32'h02);
        rdc(cbt_pkg::ADDR_RFLG, 32'h02, 32'h00);
        check({31'h0, eirq}, 32'h0);
        // Wake while asleep with wake enabled
        wr(cbt_pkg::ADDR_CTRL, 32'h0c);
        u_far.bus(1'b0);
        repeat (3) @(posedge clk);
        u_far.bus(1'b1);
        rdc(cbt_pkg::ADDR_RFLG, 32'h80, 32'h80);
        check({31'h0, wirq}, 32'h1);
        wr(cbt_pkg::ADDR_CTRL, 32'h00);
        wr(cbt_pkg::ADDR_RFLG, 32'h80);
        rdc(cbt_pkg::ADDR_RFLG, 32'h80, 32'h00);
        $display("test overrun and wake done");
        // Full flag blocks a second shift; buffer never read here
        per = shifts;
        u_far.ev(7'h40, 1);
        repeat (3) @(posedge clk);
        check(shifts, per + 1);
        rdc(cbt_pkg::ADDR_RFLG, 32'h01, 32'h01);
        check({31'h0, rirq}, 32'h1);
        u_far.ev(7'h40, 1);
        repeat (3) @(posedge clk);
        check(shifts, per + 1);
        $display("test receive full done");
        // Transmit errors: 13 steps of 8 reach warning
        u_far.ev(7'h04, 13);
        rdc(cbt_pkg::ADDR_RFLG, 32'h7c, 32'h44);
        check({31'h0, eirq}, 32'h1);
        u_far.ev(7'h04, 4);
        rdc(cbt_pkg::ADDR_ERRCNT, 32'h1ff00, 32'h8800);
        rdc(cbt_pkg::ADDR_RFLG, 32'h0c, 32'h04);
        wr(cbt_pkg::ADDR_RFLG, 32'h7c);
        rdc(cbt_pkg::ADDR_RFLG, 32'h3c, 32'h08);
        // Init holds flags at reset but keeps state codes
        u_far.ev(7'h20, 1);
        wr(cbt_pkg::ADDR_CTRL, 32'h01);
        rdc(cbt_pkg::ADDR_CTRL, 32'h03, 32'h03);
        rdc(cbt_pkg::ADDR_RFLG, 32'hff, 32'h08);
        rdc(cbt_pkg::ADDR_RIER, 32'hff, 32'h00);
        wr(cbt_pkg::ADDR_RFLG, 32'hff);
        rdc(cbt_pkg::ADDR_RFLG, 32'hff, 32'h08);
        $display("test error states and init done");
        // Valid segment settings only; triple sample at the slower bit rate
        for (int i = 0; i < 2; i++) begin
            wr(cbt_pkg::ADDR_CTRL, 32'h01);
            wr(cbt_pkg::ADDR_BTR0, {24'h0, pv[i]});
            wr(cbt_pkg::ADDR_BTR1, {24'h0, tv[i]});
            rdc(cbt_pkg::ADDR_BTR1, 32'hff, {24'h0, tv[i]});
            wr(cbt_pkg::ADDR_CTRL, 32'h00);
            measure(per);
            measure(per);
            measure(per);
            check(per, pexp[i]);
        end
        u_far.bus(1'b0);
        measure(per);
        measure(per);
        check({31'h0, bval}, 32'h0);
        u_far.bus(1'b1);
        measure(per);
        measure(per);
        check({31'h0, bval}, 32'h1);
        $display("test bit timing done");
        // Bus-off and recovery back to OK
        u_far.ev(7'h04, 16);
        rdc(cbt_pkg::ADDR_RFLG, 32'h3c, 32'h3c);
        u_far.ev(7'h01, 1);
        wr(cbt_pkg::ADDR_RFLG, 32'h40);
        rdc(cbt_pkg::ADDR_RFLG, 32'h3c, 32'h00);
        rdc(cbt_pkg::ADDR_ERRCNT, 32'h1ff00, 32'h0);
        $display("test bus off done");
        // Clock enable low freezes flags
        @(posedge clk);
        ce <= 1'b0;
        u_far.ev(7'h20, 1);
        @(posedge clk);
        ce <= 1'b1;
        rdc(cbt_pkg::ADDR_RFLG, 32'h02, 32'h00);
        $display("test clock enable done");
        tally_and_finish;
    end
endmodule : tb_cbt_top
`default_nettype wire
